// file: logic/dum_top.sv
// Top level of the dual channel modem and interrupt pin logic.
`timescale 1ns/1ps
module dum_top (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_ctrl_wr_a,
  input  wire logic                        i_ctrl_wr_b,
  input  wire logic [dum_pkg::CTRL_W-1:0]  i_ctrl_wdata,
  input  wire logic                        i_irq_req_a,
  input  wire logic                        i_irq_req_b,
  input  wire logic                        i_clear_send_n_a,
  input  wire logic                        i_set_ready_n_a,
  input  wire logic                        i_carrier_det_n_a,
  input  wire logic                        i_ring_ind_n_a,
  input  wire logic                        i_clear_send_n_b,
  input  wire logic                        i_set_ready_n_b,
  input  wire logic                        i_carrier_det_n_b,
  input  wire logic                        i_ring_ind_n_b,
  input  wire logic                        i_serial_in_a,
  input  wire logic                        i_serial_in_b,
  output logic      [dum_pkg::CTRL_W-1:0]  o_ctrl_a,
  output logic      [dum_pkg::CTRL_W-1:0]  o_ctrl_b,
  output logic      [dum_pkg::GPI_W-1:0]   o_gpi_n_a,
  output logic      [dum_pkg::GPI_W-1:0]   o_gpi_n_b,
  output logic                             o_line_idle_a,
  output logic                             o_line_idle_b,
  output logic                             o_irq_out_a,
  output logic                             o_irq_out_a_oe,
  output logic                             o_irq_out_b,
  output logic                             o_irq_out_b_oe,
  output logic                             o_term_ready_n_a,
  output logic                             o_term_ready_n_b,
  output logic                             o_req_send_n_a,
  output logic                             o_req_send_n_b,
  output logic                             o_aux_out_two_n_a,
  output logic                             o_aux_out_two_n_b
);
  logic [dum_pkg::NUM_CH-1:0]                  wr_v;
  logic [dum_pkg::NUM_CH-1:0]                  irq_req_v;
  logic [dum_pkg::NUM_CH-1:0][dum_pkg::GPI_W-1:0] gpi_in_v;
  logic [dum_pkg::NUM_CH-1:0][dum_pkg::GPI_W-1:0] gpi_out_v;
  logic [dum_pkg::NUM_CH-1:0][dum_pkg::CTRL_W-1:0] ctrl_v;
  logic [dum_pkg::NUM_CH-1:0]                  irq_v;
  logic [dum_pkg::NUM_CH-1:0]                  irq_oe_v;
  logic [dum_pkg::NUM_CH-1:0]                  dtr_v;
  logic [dum_pkg::NUM_CH-1:0]                  rts_v;
  logic [dum_pkg::NUM_CH-1:0]                  aux_v;
  logic [dum_pkg::NUM_CH-1:0]                  mode_v;
  logic [dum_pkg::NUM_CH-1:0][dum_pkg::CTRL_W-1:0] ctrl_q;

  // Gather per channel inputs into vectors for the channel loop.
  assign wr_v      = {i_ctrl_wr_b, i_ctrl_wr_a};
  assign irq_req_v = {i_irq_req_b, i_irq_req_a};
  assign gpi_in_v[0] = {i_ring_ind_n_a, i_carrier_det_n_a, i_set_ready_n_a, i_clear_send_n_a};
  assign gpi_in_v[1] = {i_ring_ind_n_b, i_carrier_det_n_b, i_set_ready_n_b, i_clear_send_n_b};

  // One channel instance per channel, each with its own control byte.
  for (genvar ch = 0; ch < dum_pkg::NUM_CH; ch++) begin : g_ch
    dum_chan u_chan (
      .i_ref_clk       (i_ref_clk),
      .i_sys_rst       (i_sys_rst),
      .i_wr            (wr_v[ch]),
      .i_wdata         (i_ctrl_wdata),
      .i_irq_req       (irq_req_v[ch]),
      .i_gpi_n         (gpi_in_v[ch]),
      .o_ctrl          (ctrl_v[ch]),
      .o_gpi_n         (gpi_out_v[ch]),
      .o_irq           (irq_v[ch]),
      .o_irq_oe        (irq_oe_v[ch]),
      .o_term_ready_n  (dtr_v[ch]),
      .o_req_send_n    (rts_v[ch]),
      .o_aux_out_two_n (aux_v[ch]),
      .o_mode          (mode_v[ch])
    );
  end

  // Registered copy of the control bytes for host readback.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_v;
    end
  end

  // Receive line idle indication, registered; the peer keeps it high.
  // idle line high
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_line_idle_a <= 1'b1;
      o_line_idle_b <= 1'b1;
    end else begin
      o_line_idle_a <= (i_serial_in_a == dum_pkg::LINE_IDLE);
      o_line_idle_b <= (i_serial_in_b == dum_pkg::LINE_IDLE);
    end
  end

  // Channel flop outputs and the registered control copies map straight onto pins.
  assign o_ctrl_a          = ctrl_q[0];
  assign o_ctrl_b          = ctrl_q[1];
  assign o_gpi_n_a         = gpi_out_v[0];
  assign o_gpi_n_b         = gpi_out_v[1];
  assign o_irq_out_a       = irq_v[0];
  assign o_irq_out_b       = irq_v[1];
  assign o_irq_out_a_oe    = irq_oe_v[0];
  assign o_irq_out_b_oe    = irq_oe_v[1];
  assign o_term_ready_n_a  = dtr_v[0];
  assign o_term_ready_n_b  = dtr_v[1];
  assign o_req_send_n_a    = rts_v[0];
  assign o_req_send_n_b    = rts_v[1];
  // Aux two shares the enable bit, so it tracks the interrupt drive.
  assign o_aux_out_two_n_a = aux_v[0];
  assign o_aux_out_two_n_b = aux_v[1];
endmodule

// file: logic/dum_pkg.sv
// Package with constants for the dual channel modem pin logic.
package dum_pkg;
  localparam int          NUM_CH       = 2;
  localparam int          CTRL_W       = 8;
  // Bit positions inside the modem control byte.
  localparam int          BIT_TERM_RDY = 0;
  localparam int          BIT_REQ_SEND = 1;
  localparam int          BIT_AUX_ONE  = 2;
  localparam int          BIT_IRQ_EN   = 3;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam int          GPI_W        = 4;
  localparam logic [3:0]  GPI_RESET    = 4'hF;
  // Least host reset pulse, and that pulse in clock cycles at 100 MHz.
  localparam int          CLK_PERIOD_PS = 10000;
  localparam int          RST_MIN_PS    = 40000;
  localparam int          RST_MIN_CYC   = (RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Idle level of the receive line.
  localparam logic        LINE_IDLE     = 1'b1;
  // Channel state machine codes.
  typedef enum logic [0:0] {
    CH_QUIET  = 1'b0,
    CH_ACTIVE = 1'b1
  } dum_irq_mode_t;
endpackage

// file: logic/dum_chan.sv
// One channel of modem control storage and its pin drivers.
`timescale 1ns/1ps
module dum_chan (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_wr,
  input  wire logic [dum_pkg::CTRL_W-1:0]  i_wdata,
  input  wire logic                        i_irq_req,
  input  wire logic [dum_pkg::GPI_W-1:0]   i_gpi_n,
  output logic      [dum_pkg::CTRL_W-1:0]  o_ctrl,
  output logic      [dum_pkg::GPI_W-1:0]   o_gpi_n,
  output logic                             o_irq,
  output logic                             o_irq_oe,
  output logic                             o_term_ready_n,
  output logic                             o_req_send_n,
  output logic                             o_aux_out_two_n,
  output logic                             o_mode
);
  logic [dum_pkg::CTRL_W-1:0] ctrl_q;
  dum_pkg::dum_irq_mode_t     mode_q;

  // Control byte storage, cleared by reset.
  // reset clears control
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= dum_pkg::CTRL_RESET;
    end else if (i_wr) begin
      ctrl_q <= i_wdata;
    end
  end

  // Interrupt pin mode follows the enable bit of this channel only.
  // own bit only
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_q <= dum_pkg::CH_QUIET;
    end else begin
      case (i_wr ? i_wdata[dum_pkg::BIT_IRQ_EN] : ctrl_q[dum_pkg::BIT_IRQ_EN])
        1'b1:    mode_q <= dum_pkg::CH_ACTIVE;
        default: mode_q <= dum_pkg::CH_QUIET;
      endcase
    end
  end

  // Pin drivers, each registered so the outputs come straight from flops.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq           <= 1'b0;
      o_irq_oe        <= 1'b0;
      o_aux_out_two_n <= 1'b1;
      o_term_ready_n  <= 1'b1;
      o_req_send_n    <= 1'b1;
      o_gpi_n         <= dum_pkg::GPI_RESET;
    end else begin
      o_irq_oe        <= (mode_q == dum_pkg::CH_ACTIVE);
      o_irq           <= (mode_q == dum_pkg::CH_ACTIVE) && i_irq_req;
      o_aux_out_two_n <= (mode_q != dum_pkg::CH_ACTIVE);
      o_term_ready_n  <= ~ctrl_q[dum_pkg::BIT_TERM_RDY];
      o_req_send_n    <= ~ctrl_q[dum_pkg::BIT_REQ_SEND];
      o_gpi_n         <= i_gpi_n;
    end
  end

  assign o_ctrl = ctrl_q;
  assign o_mode = mode_q;
endmodule

// file: sim/dum_top_checker.sv
// Checker of the interrupt and modem pin behaviour at the top ports.
`timescale 1ns/1ps
module dum_top_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_ctrl_wr_a,
  input wire logic       i_ctrl_wr_b,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic       i_clear_send_n_a,
  input wire logic [3:0] o_gpi_n_a,
  input wire logic       o_irq_out_a_oe,
  input wire logic       o_aux_out_two_n_a,
  input wire logic       o_irq_out_b_oe,
  input wire logic       o_term_ready_n_a,
  input wire logic       o_req_send_n_b
);
  // Checks run on the rising edge and rest while reset is high.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_drv_a;
    i_ctrl_wr_a && i_ctrl_wdata[3] |-> ##2 o_irq_out_a_oe && !o_aux_out_two_n_a; endproperty
  a_drv_a: assert property (p_drv_a) else $error("irq a not driven");
  property p_flt_a;
    i_ctrl_wr_a && !i_ctrl_wdata[3] |-> ##2 !o_irq_out_a_oe && o_aux_out_two_n_a; endproperty
  a_flt_a: assert property (p_flt_a) else $error("irq a not floated");
  property p_chan_b;
    i_ctrl_wr_b |-> ##2 o_irq_out_b_oe == $past(i_ctrl_wdata[3], 2); endproperty
  a_chan_b: assert property (p_chan_b) else $error("irq b enable wrong");
  property p_own_b;
    !i_ctrl_wr_b ##1 !i_ctrl_wr_b |-> ##1 $stable(o_irq_out_b_oe); endproperty
  a_own_b: assert property (p_own_b) else $error("irq b moved");
  property p_gpi_a;
    1'b1 |=> o_gpi_n_a[0] == $past(i_clear_send_n_a); endproperty
  a_gpi_a: assert property (p_gpi_a) else $error("gp input a wrong");
  property p_dtr_a;
    i_ctrl_wr_a |-> ##2 o_term_ready_n_a == !$past(i_ctrl_wdata[0], 2); endproperty
  a_dtr_a: assert property (p_dtr_a) else $error("ready a wrong");
  property p_rts_b;
    i_ctrl_wr_b |-> ##2 o_req_send_n_b == !$past(i_ctrl_wdata[1], 2); endproperty
  a_rts_b: assert property (p_rts_b) else $error("request b wrong");
  property p_rst;
    $fell(i_sys_rst) |-> !o_irq_out_a_oe && o_aux_out_two_n_a; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind dum_top dum_top_checker chk_u (.*);

// file: sim/dum_modem_model.sv
// Modem peer model driving one channel's handshake and receive lines.
`timescale 1ns/1ps
module dum_modem_model (
  input  wire logic i_ref_clk,
  input  wire logic i_slow,
  input  wire logic i_req_send_n,
  output logic      o_clear_send_n,
  output logic [2:0] o_status_n,
  output logic      o_serial_in
);
  logic late_q;
  assign o_serial_in = 1'b1;
  // Echoes the request promptly or a cycle late; status lines wander.
  initial {o_clear_send_n, o_status_n} = 4'hF;
  always @(negedge i_ref_clk) begin
    late_q         <= i_req_send_n;
    o_clear_send_n <= i_slow ? late_q : i_req_send_n;
    o_status_n     <= 3'($urandom);
  end
endmodule

// file: sim/dum_top_tb.sv
// Self-checking bench for the dual channel modem and interrupt pin logic.
`timescale 1ns/1ps
module dum_top_tb;
  logic       i_ref_clk = 1'b0, i_sys_rst = 1'b1, slow = 1'b0, i_ctrl_wr_a = 1'b0;
  logic       i_ctrl_wr_b = 1'b0, i_irq_req_a = 1'b0, i_irq_req_b = 1'b0;
  logic [7:0] i_ctrl_wdata = 8'h00, ea = 8'h00, eb = 8'h00, o_ctrl_a, o_ctrl_b;
  logic [3:0] o_gpi_n_a, o_gpi_n_b;
  logic       o_line_idle_a, o_line_idle_b, o_irq_out_a, o_irq_out_a_oe, o_irq_out_b;
  logic       o_irq_out_b_oe, o_term_ready_n_a, o_term_ready_n_b, o_req_send_n_a;
  logic       o_req_send_n_b, o_aux_out_two_n_a, o_aux_out_two_n_b;
  wire        i_clear_send_n_a, i_set_ready_n_a, i_carrier_det_n_a, i_ring_ind_n_a;
  wire        i_clear_send_n_b, i_set_ready_n_b, i_carrier_det_n_b, i_ring_ind_n_b;
  wire        i_serial_in_a, i_serial_in_b;
  int         errors = 0, n_tests = 0;
  // Pin groups: enable, aux, ready, request, irq value.
  wire [7:0]  pa = {3'h0, o_irq_out_a_oe, o_aux_out_two_n_a, o_term_ready_n_a,
                    o_req_send_n_a, o_irq_out_a};
  wire [7:0]  pb = {3'h0, o_irq_out_b_oe, o_aux_out_two_n_b, o_term_ready_n_b,
                    o_req_send_n_b, o_irq_out_b};
  always #5 i_ref_clk = ~i_ref_clk;
  dum_top dut_u (.*);
  dum_modem_model mdm_a (.i_ref_clk, .i_slow(slow), .i_req_send_n(o_req_send_n_a),
    .o_clear_send_n(i_clear_send_n_a), .o_serial_in(i_serial_in_a),
    .o_status_n({i_ring_ind_n_a, i_carrier_det_n_a, i_set_ready_n_a}));
  dum_modem_model mdm_b (.i_ref_clk, .i_slow(slow), .i_req_send_n(o_req_send_n_b),
    .o_clear_send_n(i_clear_send_n_b), .o_serial_in(i_serial_in_b),
    .o_status_n({i_ring_ind_n_b, i_carrier_det_n_b, i_set_ready_n_b}));
  task automatic chk(input string name, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] pins(input logic [7:0] d, input logic req);
    return {3'h0, d[3], ~d[3], ~d[0], ~d[1], d[3] & req};
  endfunction
  // bit three used as irq enable, shared by aux two
  task automatic put(input logic wa, wb, input logic [7:0] d);
    @(negedge i_ref_clk);
    {i_ctrl_wr_a, i_ctrl_wr_b, i_ctrl_wdata} <= {wa, wb, d};
    {i_irq_req_a, i_irq_req_b} <= 2'($urandom);
    if (wa) ea = d;
    if (wb) eb = d;
  endtask
  // Ends the write and compares both channels once settled.
  task automatic look();
    @(negedge i_ref_clk);
    {i_ctrl_wr_a, i_ctrl_wr_b} <= 2'h0;
    repeat (3) @(negedge i_ref_clk);
    chk("pins_a", pa, pins(ea, i_irq_req_a));
    chk("pins_b", pb, pins(eb, i_irq_req_b));
    chk("ctrl_a", o_ctrl_a, ea);
    chk("ctrl_b", o_ctrl_b, eb);
    chk("idle", {6'h00, o_line_idle_a, o_line_idle_b}, 8'h03);
    chk("gpi_a", {4'h0, o_gpi_n_a}, {4'h0, i_ring_ind_n_a, i_carrier_det_n_a, i_set_ready_n_a, i_clear_send_n_a});
    chk("gpi_b", {4'h0, o_gpi_n_b}, {4'h0, i_ring_ind_n_b, i_carrier_det_n_b, i_set_ready_n_b, i_clear_send_n_b});
  endtask
  task automatic results();
    $display("checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence: reset state, corner writes, random writes, mid-run reset.
  initial begin
    void'($urandom(41));
    repeat (16) @(negedge i_ref_clk);
    i_sys_rst <= 1'b0;
    look();
    for (int i = 0; i < 16; i++) begin
      put(i[3], !i[3], {4'h0, i[2], 1'b0, i[1:0]});
      look();
    end
    for (int i = 0; i < 40; i++) begin
      slow <= i[4];
      put(1'($urandom), 1'($urandom), 8'($urandom));
      if (i[0]) put(1'($urandom), 1'($urandom), 8'($urandom));
      look();
    end
    @(negedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (5) @(negedge i_ref_clk);
    i_sys_rst <= 1'b0;
    {ea, eb} = 16'h0000;
    look();
    results();
  end
endmodule
